// ===== design/fe_err_stat_regs.vh
`ifndef FE_ERR_STAT_REGS_VH
`define FE_ERR_STAT_REGS_VH

// ----------------------------------------
// register offsets on the management bus
// ----------------------------------------
`define FE_OFS_CODING_CFG 5'h17
`define FE_OFS_OWN_STATUS 5'h19

// ----------------------------------------
// coding sublayer config field positions
// ----------------------------------------
`define FE_CFG_CODE_SEL 4
`define FE_CFG_LINK_EN 2
`define FE_CFG_PKT_EN 1
`define FE_CFG_CODE_EN 0
`define FE_CFG_RESET 5'h00

// ----------------------------------------
// own status field positions
// ----------------------------------------
`define FE_ST_LINK_OK 15
`define FE_ST_LOW_POWER 14
`define FE_ST_RX_VALID 13
`define FE_ST_DESCR_LOCK 12
`define FE_ST_PAUSE 9
`define FE_ST_DUPLEX 7
`define FE_ST_TEN_MODE 6
`define FE_ST_LOW_POWER_RESET 1'b1

// ----------------------------------------
// error nibbles driven toward the mac
// ----------------------------------------
`define FE_NIB_LINK_ERR 4'h3
`define FE_NIB_PKT_ERR 4'h2
`define FE_NIB_CODE_SEL1 4'h5
`define FE_NIB_CODE_SEL0 4'h6

// ----------------------------------------
// management frame counts
// ----------------------------------------
`define FE_PREAMBLE_ONES 6'd32
`define FE_HDR_BITS 4'd12
`define FE_DATA_BITS 5'd16
`define FE_OP_READ 2'b10
`define FE_OP_WRITE 2'b01

`endif

// ===== design/fe_pin_sync.v
`timescale 1ns/1ps
// three-flop sampler per bit; level moves only when stages two and three agree
module fe_pin_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] pin,
  output reg [WIDTH-1:0] level,
  output reg [WIDTH-1:0] rise
);
  reg [WIDTH-1:0] s1; // first stage, read only by s2
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // ----------------------------------------
      // sampler chain and agreed level
      // ----------------------------------------
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          level[i] <= 1'b0;
          rise[i] <= 1'b0;
        end else begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // a lone glitch in stage two never reaches the level
          if (s2[i] == s3[i]) begin
            level[i] <= s3[i];
          end
          rise[i] <= (s2[i] == s3[i]) && s3[i] && !level[i];
        end
      end
    end
  endgenerate
endmodule

// ===== design/fe_err_stat.v
`timescale 1ns/1ps
`include "fe_err_stat_regs.vh"
// receive error reporting and own-status bank behind the management pins
module fe_err_stat (
  input wire clk,
  input wire rst,
  // management pins
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe,
  input wire [4:0] phy_addr_strap,
  // mii clocks and pins
  input wire rx_clk,
  input wire tx_er,
  output reg [3:0] rxd,
  output reg rx_er,
  output reg tx_halt,
  // receive datapath, same clock
  input wire [3:0] dp_rxd,
  input wire dp_rx_er,
  input wire dp_rx_dv,
  input wire link_err,
  input wire pkt_err,
  input wire code_err,
  // device state, same clock
  input wire compat_mode,
  input wire link_ok,
  input wire low_power,
  input wire descr_lock,
  input wire ten_mode,
  input wire full_duplex,
  input wire pause_done
);
  // ----------------------------------------
  // state encodings
  // ----------------------------------------
  localparam [4:0] ST_PRE = 5'b00001; // counting preamble ones
  localparam [4:0] ST_START = 5'b00010; // second start bit
  localparam [4:0] ST_HDR = 5'b00100; // op, phy and register address
  localparam [4:0] ST_TA = 5'b01000; // turnaround
  localparam [4:0] ST_DATA = 5'b10000; // sixteen data bits

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  wire [3:0] pin_level;
  wire [3:0] pin_rise;
  fe_pin_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin({tx_er, rx_clk, mdio_in, mdc}),
    .level(pin_level),
    .rise(pin_rise)
  );
  wire mdc_rise = pin_rise[0]; // management bit clock edge
  wire mdio_bit = pin_level[1]; // agreed data level
  wire rxc_rise = pin_rise[2]; // mii receive clock edge
  wire tx_er_lvl = pin_level[3];

  // ----------------------------------------
  // registers and status capture
  // ----------------------------------------
  reg [4:0] cfg; // coding sublayer config bits 4:0
  reg [15:0] status; // own status image
  reg [4:0] phy_addr; // strap caught after reset release
  reg strap_done;
  wire code_en = cfg[`FE_CFG_CODE_EN] & ~compat_mode;

  // strap capture runs after reset, so no port feeds an async load
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phy_addr <= 5'h00;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      phy_addr <= phy_addr_strap;
      strap_done <= 1'b1;
    end
  end

  // status bits track device state each cycle; unowned bits read zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= 16'h0000;
      status[`FE_ST_LOW_POWER] <= `FE_ST_LOW_POWER_RESET;
    end else begin
      status <= 16'h0000;
      status[`FE_ST_LINK_OK] <= link_ok;
      status[`FE_ST_LOW_POWER] <= low_power;
      status[`FE_ST_RX_VALID] <= dp_rx_dv;
      status[`FE_ST_DESCR_LOCK] <= descr_lock;
      status[`FE_ST_PAUSE] <= pause_done;
      status[`FE_ST_DUPLEX] <= full_duplex;
      status[`FE_ST_TEN_MODE] <= ten_mode;
    end
  end

  // read decode, used by the frame engine
  function [15:0] read_word;
    input [4:0] ofs;
    input [4:0] cfg_v;
    input [15:0] st_v;
    begin
      if (ofs == `FE_OFS_CODING_CFG) begin
        read_word = {11'h000, cfg_v};
      end else if (ofs == `FE_OFS_OWN_STATUS) begin
        read_word = st_v;
      end else begin
        read_word = 16'h0000; // unmapped reads as zero
      end
    end
  endfunction

  // ----------------------------------------
  // management frame engine
  // ----------------------------------------
  reg [4:0] state;
  reg [5:0] ones_cnt; // saturating preamble count
  reg [4:0] bit_cnt; // bits seen in header or data
  reg [11:0] hdr; // op, phy address, register address
  reg [15:0] shreg; // read data out or write data in
  reg hit; // frame addresses this phy
  reg wr_pulse; // one-cycle write strobe
  reg [4:0] wr_ofs;
  reg [15:0] wr_data;
  wire [11:0] next_hdr = {hdr[10:0], mdio_bit};
  wire [15:0] next_shreg = {shreg[14:0], mdio_bit};

  // shifts one bit per management clock edge; no preamble suppression
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_PRE;
      ones_cnt <= 6'd0;
      bit_cnt <= 5'd0;
      hdr <= 12'h000;
      shreg <= 16'h0000;
      hit <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
      wr_pulse <= 1'b0;
      wr_ofs <= 5'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_pulse <= 1'b0;
      if (mdc_rise) begin
        case (state)
          ST_PRE: begin
            mdio_oe <= 1'b0;
            if (mdio_bit) begin
              if (ones_cnt != `FE_PREAMBLE_ONES) begin
                ones_cnt <= ones_cnt + 6'd1;
              end
            end else begin
              // a zero ends the preamble only after enough ones
              if (ones_cnt == `FE_PREAMBLE_ONES) begin
                state <= ST_START;
              end
              ones_cnt <= 6'd0;
            end
          end
          ST_START: begin
            bit_cnt <= 5'd0;
            state <= mdio_bit ? ST_HDR : ST_PRE;
          end
          ST_HDR: begin
            hdr <= next_hdr;
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == {1'b0, `FE_HDR_BITS} - 5'd1) begin
              hit <= (next_hdr[9:5] == phy_addr) &&
                     ((next_hdr[11:10] == `FE_OP_READ) ||
                      (next_hdr[11:10] == `FE_OP_WRITE));
              shreg <= read_word(next_hdr[4:0], cfg, status);
              bit_cnt <= 5'd0;
              state <= ST_TA;
            end
          end
          ST_TA: begin
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == 5'd0) begin
              // master released the line; claim it with the zero bit
              if (hit && hdr[11:10] == `FE_OP_READ) begin
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
              end
            end else begin
              mdio_out <= shreg[15];
              shreg <= {shreg[14:0], 1'b0};
              bit_cnt <= 5'd0;
              state <= ST_DATA;
            end
          end
          ST_DATA: begin
            bit_cnt <= bit_cnt + 5'd1;
            if (hdr[11:10] == `FE_OP_READ) begin
              mdio_out <= shreg[15];
              shreg <= {shreg[14:0], 1'b0};
            end else begin
              shreg <= next_shreg;
            end
            if (bit_cnt == `FE_DATA_BITS - 5'd1) begin
              // last bit: release the line, commit any write
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              if (hit && hdr[11:10] == `FE_OP_WRITE) begin
                wr_pulse <= 1'b1;
                wr_ofs <= hdr[4:0];
                wr_data <= next_shreg;
              end
              ones_cnt <= 6'd0;
              state <= ST_PRE;
            end
          end
          default: begin
            state <= ST_PRE;
          end
        endcase
      end
    end
  end

  // config register write; the code enable holds while compat mode is on
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= `FE_CFG_RESET;
    end else if (wr_pulse && wr_ofs == `FE_OFS_CODING_CFG) begin
      cfg[4:1] <= wr_data[4:1];
      if (!compat_mode) begin
        cfg[`FE_CFG_CODE_EN] <= wr_data[`FE_CFG_CODE_EN];
      end
    end
  end

  // ----------------------------------------
  // receive error injection
  // ----------------------------------------
  reg link_pend; // error seen, waiting for the next receive clock edge
  reg pkt_pend;
  reg code_pend;

  // events are held until the next receive clock edge, which clears all three whether carried out or not;
  // a fresh event in the consuming cycle stays pending (set wins)
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      link_pend <= 1'b0;
      pkt_pend <= 1'b0;
      code_pend <= 1'b0;
    end else begin
      link_pend <= (link_err & cfg[`FE_CFG_LINK_EN]) | (link_pend & ~rxc_rise);
      pkt_pend <= (pkt_err & cfg[`FE_CFG_PKT_EN]) | (pkt_pend & ~rxc_rise);
      code_pend <= (code_err & code_en) | (code_pend & ~rxc_rise);
    end
  end

  // mii outputs move on the sampled receive clock edge; code beats packet beats link
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd <= 4'h0;
      rx_er <= 1'b0;
    end else if (rxc_rise) begin
      if (code_pend && code_en) begin
        rxd <= cfg[`FE_CFG_CODE_SEL] ? `FE_NIB_CODE_SEL1 : `FE_NIB_CODE_SEL0;
        rx_er <= 1'b1;
      end else if (pkt_pend && cfg[`FE_CFG_PKT_EN]) begin
        rxd <= `FE_NIB_PKT_ERR;
        rx_er <= 1'b1;
      end else if (link_pend && cfg[`FE_CFG_LINK_EN]) begin
        rxd <= `FE_NIB_LINK_ERR;
        rx_er <= 1'b1;
      end else begin
        rxd <= dp_rxd;
        rx_er <= dp_rx_er;
      end
    end
  end

  // transmit halt request to the encoder, gated by the code enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_halt <= 1'b0;
    end else begin
      tx_halt <= tx_er_lvl & code_en;
    end
  end
endmodule

// ===== testbench/fe_err_stat_sva.sv
`timescale 1ns/1ps
// ----
// pin checker for the error and status bank
// ----
module fe_err_stat_chk (
  input wire clk,
  input wire rst,
  input wire mdc,
  input wire mdio_out,
  input wire mdio_oe,
  input wire rx_clk,
  input wire tx_er,
  input wire [3:0] rxd,
  input wire rx_er,
  input wire tx_halt,
  input wire dp_rx_er,
  input wire link_err,
  input wire pkt_err,
  input wire code_err,
  input wire compat_mode
);
  reg rq, mq; // raw clock levels a cycle back
  reg [7:0] ra, ma, ea; // ages since rx_clk rise, mdc rise, error event
  // ages wrap; a wrap can hide a fault but never raise a false one
  always @(posedge clk or posedge rst)
    if (rst) {rq, mq, ra, ma, ea} <= 26'h0;
    else begin
      {rq, mq} <= {rx_clk, mdc};
      ra <= (rx_clk && !rq) ? 8'h0 : ra + 8'h1;
      ma <= (mdc && !mq) ? 8'h0 : ma + 8'h1;
      ea <= (link_err || pkt_err || code_err) ? 8'h0 : ea + 8'h1;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_err_cause: assert property ($rose(rx_er) |-> ea <= 8'd20)
    else $error("rx_er without event");
  a_err_value: assert property ($rose(rx_er) && !$past(dp_rx_er) |-> rxd inside {2, 3, 5, 6})
    else $error("bad error nibble");
  a_err_hold: assert property ($rose(rx_er) |-> rx_er [*5])
    else $error("error nibble too short");
  a_mii_timing: assert property ($changed({rxd, rx_er}) |-> ra >= 2 && ra <= 6)
    else $error("rxd moved off rx_clk");
  a_halt_idle: assert property (!tx_er [*7] |-> !tx_halt)
    else $error("halt without tx_er");
  a_halt_cause: assert property ($rose(tx_halt) |-> $past(tx_er, 3) || $past(tx_er, 4))
    else $error("halt rose early");
  a_halt_compat: assert property (compat_mode [*6] |-> !tx_halt)
    else $error("halt in compat mode");
  a_oe_rise: assert property ($rose(mdio_oe) |-> !mdio_out && ma <= 6 ##1 mdio_oe [*8])
    else $error("bad turnaround");
endmodule
bind fe_err_stat fe_err_stat_chk u_chk (.clk(clk), .rst(rst), .mdc(mdc),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_clk(rx_clk), .tx_er(tx_er), .rxd(rxd),
  .rx_er(rx_er), .tx_halt(tx_halt), .dp_rx_er(dp_rx_er), .link_err(link_err),
  .pkt_err(pkt_err), .code_err(code_err), .compat_mode(compat_mode));

// ===== testbench/fe_mac_model.sv
`timescale 1ns/1ps
// far-end mac: free 80 ns receive clock, halt request, nibble capture
module fe_mac_model (
  input wire halt_req,
  input wire [3:0] rxd,
  input wire rx_er,
  output reg rx_clk = 1'b0,
  output reg tx_er = 1'b0,
  output reg [3:0] cap_rxd = 4'h0,
  output reg cap_er = 1'b0
);
  // odd start offset keeps this clock out of phase with clk
  initial begin
    #3;
    forever #40 rx_clk = ~rx_clk;
  end
  // mii lines launched and taken on the receive clock rise
  always @(posedge rx_clk) begin
    tx_er <= halt_req;
    cap_rxd <= rxd;
    cap_er <= rx_er;
  end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`include "fe_err_stat_regs.vh"
module tb_top;
  // ----
  // bench state
  // ----
  localparam [4:0] cfg_ofs = `FE_OFS_CODING_CFG;
  localparam [4:0] st_ofs = `FE_OFS_OWN_STATUS;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg mdc = 1'b0;
  reg hm = 1'b1; // host mdio drive; released reads as pulled high
  reg halt_req = 1'b0;
  reg compat_mode = 1'b0;
  reg [2:0] evt = 3'h0; // code, packet, link pulses
  reg [6:0] st = 7'h0; // link, power, valid, lock, pause, duplex, ten
  reg [3:0] dp_rxd = 4'h0;
  reg [31:0] seed = 32'h7f47;
  reg [4:0] expq[$]; // expected {rx_er, rxd}
  reg [15:0] rd;
  integer miscompares = 0;
  integer tests_run = 0;
  integer s;
  wire mdio_out, mdio_oe, rx_clk, tx_er, rx_er, tx_halt, cap_er;
  wire [3:0] rxd, cap_rxd;
  wire mdio_in = mdio_oe ? mdio_out : hm;
  always #5 clk = ~clk;
  fe_err_stat DUT (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr_strap(5'h05), .rx_clk(rx_clk),
    .tx_er(tx_er), .rxd(rxd), .rx_er(rx_er), .tx_halt(tx_halt), .dp_rxd(dp_rxd),
    .dp_rx_er(1'b0), .dp_rx_dv(st[4]), .link_err(evt[0]), .pkt_err(evt[1]),
    .code_err(evt[2]), .compat_mode(compat_mode), .link_ok(st[6]), .low_power(st[5]),
    .descr_lock(st[3]), .ten_mode(st[0]), .full_duplex(st[1]), .pause_done(st[2]));
  fe_mac_model mac (.halt_req(halt_req), .rxd(rxd), .rx_er(rx_er), .rx_clk(rx_clk),
    .tx_er(tx_er), .cap_rxd(cap_rxd), .cap_er(cap_er));
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk_reg(input [127:0] n, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task chk_mii(input [127:0] n, input [4:0] e, input [4:0] g);
    chk_reg(n, {11'h0, e}, {11'h0, g});
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // one bit: data moves while mdc is low, wire sampled late in the high half
  task bit_io(input b, output o);
    begin
      hm <= b;
      mdc <= 1'b0;
      repeat (10) @(posedge clk);
      mdc <= 1'b1;
      repeat (10) @(posedge clk);
      o = mdio_in;
    end
  endtask
  // whole frame; read data are the samples from the second turnaround bit up to the last bit but one
  task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd);
    integer i;
    reg b;
    reg [31:0] w;
    begin
      w = {2'b01, op, pa, ra, (op == 2'b01) ? 2'b10 : 2'b11, wd};
      for (i = 0; i < 32; i = i + 1)
        bit_io(1'b1, b);
      for (i = 31; i >= 0; i = i - 1) begin
        bit_io(w[i], b);
        if (i > 0)
          rd = {rd[14:0], b};
      end
      bit_io(1'b1, b);
    end
  endtask
  // pulse events together; spacing leaves about four receive clocks per nibble
  task inject(input [2:0] m, input [4:0] e);
    begin
      evt <= m;
      @(posedge clk);
      evt <= 3'h0;
      if (e[4])
        expq.push_back(e);
      repeat (32) @(posedge clk);
    end
  endtask
  // capture is read mid-period, where it has settled
  always @(negedge rx_clk)
    if (cap_er !== 1'b0)
      chk_mii("rx nibble", expq.size() ? expq.pop_front() : 5'h0, {cap_er, cap_rxd});
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    frame(2'b10, 5'h05, cfg_ofs, 16'hffff);
    chk_reg("cfg reset", 16'h0000, rd);
    for (s = 0; s < 6; s = s + 1) begin
      seed = nxt(seed);
      st <= seed[6:0];
      dp_rxd <= seed[10:7];
      frame(2'b10, 5'h05, st_ofs, 16'hffff);
      chk_reg("status", {st[6:3], 2'h0, st[2], 1'b0, st[1:0], 6'h0}, rd);
    end
    frame(2'b10, 5'h09, st_ofs, 16'hffff);
    chk_reg("other phy", 16'hffff, rd);
    $display("test status done");
    inject(3'b001, 5'h00);
    inject(3'b010, 5'h00);
    inject(3'b100, 5'h00);
    frame(2'b01, 5'h05, cfg_ofs, 16'hffff);
    frame(2'b10, 5'h05, cfg_ofs, 16'hffff);
    chk_reg("cfg rw", 16'h001f, rd);
    for (s = 0; s < 2; s = s + 1) begin
      frame(2'b01, 5'h05, cfg_ofs, {11'h0, s[0], 4'h7});
      inject(3'b001, 5'h13);
      inject(3'b010, 5'h12);
      inject(3'b100, s ? 5'h15 : 5'h16);
      inject(3'b111, s ? 5'h15 : 5'h16);
    end
    $display("test errors done");
    halt_req <= 1'b1;
    repeat (40) @(posedge clk);
    chk_mii("halt on", 5'h01, {4'h0, tx_halt});
    compat_mode <= 1'b1;
    inject(3'b100, 5'h00);
    chk_mii("halt compat", 5'h00, {4'h0, tx_halt});
    frame(2'b01, 5'h05, cfg_ofs, 16'h0016);
    compat_mode <= 1'b0;
    frame(2'b10, 5'h05, cfg_ofs, 16'hffff);
    chk_reg("cfg compat", 16'h0017, rd);
    chk_mii("halt back", 5'h01, {4'h0, tx_halt});
    frame(2'b01, 5'h05, cfg_ofs, 16'h0016);
    chk_mii("halt off", 5'h00, {4'h0, tx_halt});
    $display("test compat done");
    chk_mii("queue left", 5'h00, {4'h0, expq.size() != 0});
    print_verdict;
  end
endmodule
